// File: hdl/opsr_handler.sv
// Function
// - Command or cfg0 bit15 zero enters deep sleep
// - Deep sleep restores all registers to defaults
// - Array read waits latency, bus released meanwhile
// - Array write waits latency before data
// - Latch set by enable, kept after array writes
// - Write disable blocks array and register changes
// - Register read uses read latency, bus released
// - Register write has no latency cycles
// - Register write ignores strobe mask
// - Masked array bytes are not stored
// - Strobe driven during command/address, high in 2X mode
// - Reads drive strobe aligned with data
// - Array bytes return in written order
// - Writes execute only while latch set
// - Register write and reset clear latch
// - Register data upper byte first
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
module opsr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         sys_clk,   // System clock
    input  wire logic         rst_n,     // Sync reset, low
    input  wire logic         in_valid,  // Push request
    output logic              in_ready,  // Room for a word
    input  wire logic [W-1:0] in_data,   // Pushed word
    output logic              out_valid, // Word available
    input  wire logic         out_ready, // Drain accepts
    output logic [W-1:0]      out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic [AW-1:0] nxt_wr;
    logic [AW-1:0] nxt_rd;
    logic [AW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_ff != FULL);
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------
// Transaction handler
// ----------------------------------------------------------------
module opsr_handler
    import opsr_pkg::*;
(
    input  wire logic       sys_clk,         // 40 MHz clock
    input  wire logic       rst_n,           // Sync reset, low
    input  wire logic       link_ck,         // Bus clock pin
    input  wire logic       link_cs_n,       // Chip select, low
    input  wire logic [7:0] dq_in,           // Data bus in
    output logic [7:0]      dq_out,          // Data bus out
    output logic            dq_oe,           // Data bus drive
    input  wire logic       read_write_strobe_mask_in,  // Strobe/mask in
    output logic            read_write_strobe_mask_out, // Strobe out
    output logic            read_write_strobe_mask_oe,  // Strobe drive
    output logic            write_permit_latch, // Latch state
    output logic            deep_power_down, // Sleep state
    output logic            write_dropped    // Buffer overrun
);
    import opsr_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              ck_q_ff;
    logic              ck_s;
    logic              cs_s;
    logic              rw_s;
    logic [7:0]        dq_s;
    logic              rise;
    logic              fall;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
            ck_q_ff  <= 1'b0;
        end else begin
            sync1_ff <= {dq_in, read_write_strobe_mask_in,
                         link_cs_n, link_ck};
            sync2_ff <= sync1_ff;
            ck_q_ff  <= sync2_ff[0];
        end
    end

    assign ck_s = sync2_ff[0];
    assign cs_s = sync2_ff[1];
    assign rw_s = sync2_ff[2];
    assign dq_s = sync2_ff[10:3];
    assign rise = ck_s & ~ck_q_ff;
    assign fall = ~ck_s & ck_q_ff;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    opsr_state_e state_ff;
    opsr_state_e nxt_state;
    logic [7:0]  cmd_ff;
    logic [7:0]  nxt_cmd;
    logic [31:0] addr_ff;
    logic [31:0] nxt_addr;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [7:0]  hi_ff;
    logic [7:0]  nxt_hi;
    logic        mask_a_ff;
    logic        nxt_mask_a;
    logic        permit_ff;
    logic        nxt_permit;
    logic        dpd_ff;
    logic        nxt_dpd;
    logic [15:0] cfg0_ff;
    logic [15:0] nxt_cfg0;
    logic [15:0] cfg1_ff;
    logic [15:0] nxt_cfg1;
    logic [7:0]  dq_out_ff;
    logic [7:0]  nxt_dq;
    logic        dq_oe_ff;
    logic        nxt_dq_oe;
    logic        rw_ff;
    logic        nxt_rw;
    logic        rw_oe_ff;
    logic        nxt_rw_oe;
    logic        drop_ff;
    logic        nxt_drop;
    logic        data_edge;
    logic        push_req;
    logic        go_dpd;
    logic [15:0] reg_wdata;
    logic [15:0] rd_word;
    logic [15:0] reg_word;
    logic [4:0]  lat_clk;
    logic        is_read;

    logic [15:0]       mem [2**MEM_AW];
    logic              fifo_in_ready;
    logic              fifo_in_valid;
    logic [FIFO_W-1:0] fifo_in_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic              drain;
    logic [MEM_AW-1:0] drain_idx;

    assign is_read  = (cmd_ff == CMD_READ) || (cmd_ff == CMD_RREG);
    assign lat_clk  = cfg0_ff[CFG0_2X_BIT] ? LAT_1X_CLK << 1 : LAT_1X_CLK;
    assign reg_word = (addr_ff == CFG0_ADDR) ? cfg0_ff :
                      (addr_ff == CFG1_ADDR) ? cfg1_ff : 16'h0000;
    assign rd_word  = (cmd_ff == CMD_RREG) ? reg_word
                                           : mem[addr_ff[MEM_AW:1]];
    assign fifo_in_valid = push_req & fifo_in_ready;
    assign fifo_in_data  = {addr_ff[MEM_AW:1], hi_ff, dq_s,
                            mask_a_ff, rw_s};

    always_comb begin
        nxt_state  = state_ff;
        nxt_cmd    = cmd_ff;
        nxt_addr   = addr_ff;
        nxt_cnt    = cnt_ff;
        nxt_hi     = hi_ff;
        nxt_mask_a = mask_a_ff;
        nxt_permit = permit_ff;
        nxt_dpd    = dpd_ff;
        nxt_cfg0   = cfg0_ff;
        nxt_cfg1   = cfg1_ff;
        nxt_dq     = dq_out_ff;
        nxt_dq_oe  = dq_oe_ff;
        nxt_rw     = rw_ff;
        nxt_rw_oe  = rw_oe_ff;
        nxt_drop   = drop_ff;
        data_edge  = 1'b0;
        push_req   = 1'b0;
        go_dpd     = 1'b0;
        reg_wdata  = {hi_ff, dq_s};
        if (cs_s) begin
            nxt_state = ST_IDLE;
            nxt_dq_oe = 1'b0;
            nxt_rw_oe = 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    nxt_cnt   = '0;
                    nxt_drop  = 1'b0;
                    nxt_state = ST_CMD;
                    nxt_rw_oe = 1'b1;
                    nxt_rw    = cfg0_ff[CFG0_2X_BIT];
                    // Wake-up select is consumed, not decoded
                    if (dpd_ff) begin
                        nxt_dpd   = 1'b0;
                        nxt_state = ST_SKIP;
                        nxt_rw_oe = 1'b0;
                    end
                end
                ST_CMD: begin
                    if (rise) begin
                        nxt_cmd   = dq_s;
                        nxt_state = ST_SKIP;
                        nxt_rw_oe = 1'b0;
                        case (dq_s)
                            CMD_WREN: nxt_permit = 1'b1;
                            CMD_WRDI: nxt_permit = 1'b0;
                            CMD_DPD:  go_dpd  = 1'b1;
                            CMD_READ, CMD_WRITE,
                            CMD_RREG, CMD_WREG: begin
                                nxt_state = ST_ADDR;
                                nxt_rw_oe = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_ADDR: begin
                    // The command's falling edge carries no address
                    if (rise || (fall && cnt_ff != '0)) begin
                        nxt_addr = {addr_ff[23:0], dq_s};
                        nxt_cnt  = cnt_ff + 5'h01;
                        if (cnt_ff == ADDR_LAST) begin
                            nxt_cnt   = '0;
                            nxt_rw_oe = 1'b0;
                            // Register write skips latency
                            nxt_state = (cmd_ff == CMD_WREG) ?
                                        ST_WREG : ST_LAT;
                        end
                    end
                end
                ST_LAT: begin
                    // Bus stays released while dummy cycles run
                    if (rise) begin
                        if (cnt_ff == lat_clk) begin
                            data_edge = 1'b1;
                            nxt_state = is_read ? ST_RDATA : ST_WDATA;
                        end else begin
                            nxt_cnt = cnt_ff + 5'h01;
                        end
                    end
                end
                ST_RDATA, ST_WDATA: begin
                    data_edge = rise | fall;
                end
                ST_WREG: begin
                    if (rise) begin
                        nxt_hi = dq_s;
                    end else if (fall) begin
                        nxt_state = ST_SKIP;
                        // Mask line is not looked at here
                        if (permit_ff) begin
                            nxt_permit = 1'b0;
                            if (addr_ff == CFG0_ADDR) begin
                                nxt_cfg0 = reg_wdata;
                                go_dpd = !reg_wdata[CFG0_DPD_BIT];
                            end else if (addr_ff == CFG1_ADDR) begin
                                nxt_cfg1 = reg_wdata;
                            end
                        end
                    end
                end
                ST_SKIP: ;
            endcase
            if (data_edge) begin
                if (is_read) begin
                    nxt_dq_oe = 1'b1;
                    nxt_rw_oe = 1'b1;
                    nxt_rw    = rise;
                    nxt_dq    = rise ? rd_word[15:8] : rd_word[7:0];
                end else if (rise) begin
                    nxt_hi     = dq_s;
                    nxt_mask_a = rw_s;
                end else begin
                    push_req = permit_ff;
                    nxt_drop = drop_ff | (permit_ff & ~fifo_in_ready);
                end
                if (fall) begin
                    nxt_addr = addr_ff + ADDR_STEP;
                end
            end
        end
        if (go_dpd) begin
            nxt_dpd   = 1'b1;
            nxt_cfg0  = CFG0_DEFAULT;
            nxt_cfg1  = CFG1_DEFAULT;
            nxt_permit = 1'b0;
            nxt_state = ST_SKIP;
            nxt_rw_oe = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            cmd_ff    <= 8'h00;
            addr_ff   <= 32'h0000_0000;
            cnt_ff    <= 5'h00;
            hi_ff     <= 8'h00;
            mask_a_ff <= 1'b0;
            permit_ff <= 1'b0;
            dpd_ff    <= 1'b0;
            cfg0_ff   <= CFG0_DEFAULT;
            cfg1_ff   <= CFG1_DEFAULT;
            dq_out_ff <= 8'h00;
            dq_oe_ff  <= 1'b0;
            rw_ff     <= 1'b0;
            rw_oe_ff  <= 1'b0;
            drop_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cmd_ff    <= nxt_cmd;
            addr_ff   <= nxt_addr;
            cnt_ff    <= nxt_cnt;
            hi_ff     <= nxt_hi;
            mask_a_ff <= nxt_mask_a;
            permit_ff <= nxt_permit;
            dpd_ff    <= nxt_dpd;
            cfg0_ff   <= nxt_cfg0;
            cfg1_ff   <= nxt_cfg1;
            dq_out_ff <= nxt_dq;
            dq_oe_ff  <= nxt_dq_oe;
            rw_ff     <= nxt_rw;
            rw_oe_ff  <= nxt_rw_oe;
            drop_ff   <= nxt_drop;
        end
    end

    assign dq_out             = dq_out_ff;
    assign dq_oe              = dq_oe_ff;
    assign read_write_strobe_mask_out = rw_ff;
    assign read_write_strobe_mask_oe  = rw_oe_ff;
    assign write_permit_latch = permit_ff;
    assign deep_power_down    = dpd_ff;
    assign write_dropped      = drop_ff;

    // ------------------------------------------------------------
    // Array write path
    // ------------------------------------------------------------
    // Drain pauses while a read streams so the array port is free
    assign fifo_out_ready = (state_ff != ST_RDATA);
    assign drain          = fifo_out_valid & fifo_out_ready;
    assign drain_idx      = fifo_out_data[FIFO_W-1:FE_IDX_LSB];

    opsr_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (drain && !fifo_out_data[FE_MASK_A]) begin
            mem[drain_idx][15:8] <=
                fifo_out_data[FE_DATA_LSB+8 +: 8];
        end
        if (drain && !fifo_out_data[FE_MASK_B]) begin
            mem[drain_idx][7:0] <= fifo_out_data[FE_DATA_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic              chk_en_ff;
    logic [MEM_AW-1:0] chk_idx_ff;
    logic [7:0]        chk_old_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chk_en_ff  <= 1'b0;
            chk_idx_ff <= '0;
            chk_old_ff <= 8'h00;
        end else begin
            chk_en_ff  <= drain & fifo_out_data[FE_MASK_A];
            chk_idx_ff <= drain_idx;
            chk_old_ff <= mem[drain_idx][15:8];
        end
    end

    a_wren_sets: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_CMD && !cs_s && rise && dq_s == CMD_WREN)
        |=> permit_ff)
        else $error("write enable did not set latch");

    a_wrdi_clears: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_CMD && !cs_s && rise && dq_s == CMD_WRDI)
        |=> !permit_ff)
        else $error("write disable did not clear latch");

    a_dpd_entry: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_CMD && !cs_s && rise && dq_s == CMD_DPD)
        |=> dpd_ff && cfg0_ff == CFG0_DEFAULT && !permit_ff)
        else $error("deep sleep entry wrong");

    a_push_locked: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        fifo_in_valid |-> permit_ff && state_ff == ST_WDATA)
        else $error("array write pushed without latch");

    a_mask_keeps: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        chk_en_ff |-> mem[chk_idx_ff][15:8] == chk_old_ff)
        else $error("masked byte was stored");

    a_ca_strobe: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_ADDR && !cs_s)
        |-> rw_oe_ff && rw_ff == cfg0_ff[CFG0_2X_BIT])
        else $error("strobe not driven in address phase");

    a_rd_strobe: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (data_edge && is_read && !cs_s)
        |=> dq_oe_ff && rw_oe_ff && rw_ff == $past(rise))
        else $error("read strobe not aligned to data");

    a_lat_release: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        state_ff == ST_LAT |-> !dq_oe_ff && !rw_oe_ff)
        else $error("bus driven during latency");

    a_wreg_nolat: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_ADDR && !cs_s && (rise || fall) &&
         cnt_ff == ADDR_LAST && cmd_ff == CMD_WREG)
        |=> state_ff == ST_WREG)
        else $error("register write entered latency");

    a_wreg_order: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (state_ff == ST_WREG && !cs_s && fall && permit_ff &&
         addr_ff == CFG1_ADDR)
        |=> !permit_ff && cfg1_ff == {$past(hi_ff), $past(dq_s)})
        else $error("register write order or latch wrong");
endmodule

// File: hdl/opsr_pkg.sv
package opsr_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_DPD   = 8'hb9;
    localparam logic [7:0] CMD_READ  = 8'hee;
    localparam logic [7:0] CMD_WRITE = 8'hde;
    localparam logic [7:0] CMD_WREN  = 8'h06;
    localparam logic [7:0] CMD_WRDI  = 8'h04;
    localparam logic [7:0] CMD_RREG  = 8'h65;
    localparam logic [7:0] CMD_WREG  = 8'h71;
    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_LAST  = 5'h03;
    localparam logic [4:0]  LAT_1X_CLK = 5'h06;
    localparam logic [31:0] ADDR_STEP  = 32'h0000_0002;
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam logic [31:0] CFG0_ADDR    = 32'h0000_0800;
    localparam logic [31:0] CFG1_ADDR    = 32'h0000_0802;
    localparam logic [15:0] CFG0_DEFAULT = 16'h8008;
    localparam logic [15:0] CFG1_DEFAULT = 16'h0002;
    localparam int          CFG0_DPD_BIT = 15;
    localparam int          CFG0_2X_BIT  = 3;
    // ------------------------------------------------------------
    // Array and write buffer
    // ------------------------------------------------------------
    localparam int MEM_AW      = 6;
    localparam int FIFO_DEPTH  = 8;
    localparam int FE_MASK_B   = 0;
    localparam int FE_MASK_A   = 1;
    localparam int FE_DATA_LSB = 2;
    localparam int FE_IDX_LSB  = 18;
    localparam int FIFO_W      = FE_IDX_LSB + MEM_AW;
    localparam int SYNC_W      = 11;
    localparam logic [SYNC_W-1:0] SYNC_RST = 11'h002;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_LAT,
        ST_RDATA, ST_WDATA, ST_WREG, ST_SKIP
    } opsr_state_e;
endpackage

// File: verification/opsr_host_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host controller model
// ------------------------------------------------------------
module opsr_host_model (
    input  wire logic       sys_clk,   // System clock
    output logic            link_ck,   // Bus clock
    output logic            link_cs_n, // Chip select, low
    output logic [7:0]      dq_in,     // Data to device
    output logic            read_write_strobe_mask_in,  // Mask to device
    input  wire logic [7:0] dq_out,    // Data from device
    input  wire logic       dq_oe,     // Device drives data
    input  wire logic       read_write_strobe_mask_out, // Strobe in
    input  wire logic       read_write_strobe_mask_oe   // Strobe driven
);
    logic [7:0] tx [64];
    logic       tm [64];
    logic [7:0] rx [64];
    logic [2:0] rs [64];

    initial begin
        link_ck   = 1'h0;
        link_cs_n = 1'h1;
        dq_in     = 8'h00;
        read_write_strobe_mask_in = 1'h0;
    end

    task automatic grab(input int k);
        rx[k] = dq_out;
        rs[k] = {dq_oe, read_write_strobe_mask_oe,
                 read_write_strobe_mask_out};
    endtask

    // Clock idles low outside frames; it is not free-running
    task automatic txn(input int n);
        @(posedge sys_clk);
        #1;
        link_cs_n = 1'h0;
        for (int k = 0; k < n; k++) begin
            @(posedge sys_clk);
            #1;
            dq_in   = tx[k];
            read_write_strobe_mask_in = tm[k];
            repeat (3) @(posedge sys_clk);
            #1;
            // Output of the previous edge has had a full half period
            if (k > 0) grab(k - 1);
            link_ck = ~link_ck;
        end
        repeat (4) @(posedge sys_clk);
        #1;
        grab(n - 1);
        link_cs_n = 1'h1;
        // A released bus never keeps showing the last byte
        dq_in = ~dq_in;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Transaction bench
// ------------------------------------------------------------
module tb;
    import opsr_pkg::*;
    logic       sys_clk;
    logic       rst_n;
    logic       link_ck;
    logic       link_cs_n;
    logic [7:0] dq_in;
    logic [7:0] dq_out;
    logic       dq_oe;
    logic       read_write_strobe_mask_in;
    logic       read_write_strobe_mask_out;
    logic       read_write_strobe_mask_oe;
    logic       write_permit_latch;
    logic       deep_power_down;
    logic       write_dropped;
    int         bad_count = 0;
    int         n_checks = 0;
    int         n;
    int         lat;

    opsr_host_model u_host (.sys_clk, .link_ck, .link_cs_n, .dq_in,
        .read_write_strobe_mask_in, .dq_out, .dq_oe,
        .read_write_strobe_mask_out, .read_write_strobe_mask_oe);
    opsr_handler u_opsr_handler (.sys_clk, .rst_n, .link_ck, .link_cs_n,
        .dq_in, .dq_out, .dq_oe, .read_write_strobe_mask_in,
        .read_write_strobe_mask_out, .read_write_strobe_mask_oe,
        .write_permit_latch, .deep_power_down, .write_dropped);

    task automatic close_out;
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic put(input logic [7:0] d, input logic m);
        u_host.tx[n] = d;
        u_host.tm[n] = m;
        n++;
    endtask

    // l < 0: no address; the latency phase shows a changing bus
    task automatic head(input logic [7:0] c, input logic [31:0] a,
                        input int l);
        n = 0;
        put(c, 1'h0);
        put(~c, 1'h0);
        if (l >= 0) for (int i = 0; i < 4; i++) put(a[31-8*i -: 8], 1'h0);
        for (int i = 0; i < 2 * l; i++) put(8'h55 ^ i[7:0], 1'h1);
    endtask

    task automatic cmd(input logic [7:0] c);
        head(c, 32'h0, -1);
        u_host.txn(n);
    endtask

    task automatic wr(input logic [7:0] c, input logic [31:0] a,
                      input int l, input logic [31:0] d,
                      input logic [3:0] m, input int nb);
        head(c, a, l);
        for (int i = 0; i < nb; i++) put(d[31-8*i -: 8], m[3-i]);
        u_host.txn(n);
    endtask

    task automatic rd(input logic [7:0] c, input logic [31:0] a,
                      input logic [31:0] e, input int nb);
        int b;
        head(c, a, lat);
        b = n;
        for (int i = 0; i < nb; i++) put(8'h33 ^ i[7:0], 1'h0);
        u_host.txn(n);
        chk1(u_host.rs[0][1], 1'h1);
        chk1(u_host.rs[0][0], lat != LAT_1X_CLK);
        for (int i = 0; i < nb; i++) begin
            chk8(u_host.rx[b+i], e[31-8*i -: 8]);
            chk1(u_host.rs[b+i][0], i % 2 == 0);
            chk1(u_host.rs[b+i][2], 1'h1);
        end
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #300000;
        bad_count++;
        close_out;
    end

    initial begin
        rst_n = 1'h0;
        lat   = 2 * LAT_1X_CLK;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'h1;
        repeat (4) @(posedge sys_clk);
        chk1(write_permit_latch, 1'h0);
        chk1(deep_power_down, 1'h0);
        cmd(CMD_WREN);
        chk1(write_permit_latch, 1'h1);
        wr(CMD_WRITE, 32'h4, lat, 32'h12345678, 4'h0, 4);
        chk1(write_permit_latch, 1'h1);
        wr(CMD_WRITE, 32'h4, lat, 32'haabbccdd, 4'h9, 4);
        rd(CMD_READ, 32'h4, 32'h12bbcc78, 4);
        chk1(write_dropped, 1'h0);
        cmd(CMD_WRDI);
        chk1(write_permit_latch, 1'h0);
        wr(CMD_WRITE, 32'h4, lat, 32'h0, 4'h0, 4);
        rd(CMD_READ, 32'h4, 32'h12bbcc78, 4);
        wr(CMD_WREG, CFG1_ADDR, 0, 32'h5a3c0000, 4'h0, 2);
        rd(CMD_RREG, CFG1_ADDR, {CFG1_DEFAULT, 16'h0}, 2);
        cmd(CMD_WREN);
        wr(CMD_WREG, CFG1_ADDR, 0, 32'h5a3c0000, 4'hc, 2);
        chk1(write_permit_latch, 1'h0);
        rd(CMD_RREG, CFG1_ADDR, 32'h5a3c0000, 2);
        rd(CMD_RREG, CFG0_ADDR, {CFG0_DEFAULT, 16'h0}, 2);
        cmd(CMD_WREN);
        wr(CMD_WREG, CFG0_ADDR, 0, 32'h80000000, 4'h0, 2);
        lat = LAT_1X_CLK;
        rd(CMD_READ, 32'h4, 32'h12bbcc78, 4);
        cmd(CMD_WREN);
        wr(CMD_WREG, CFG0_ADDR, 0, 32'h0, 4'h0, 2);
        chk1(deep_power_down, 1'h1);
        cmd(CMD_WRDI);
        chk1(deep_power_down, 1'h0);
        lat = 2 * LAT_1X_CLK;
        rd(CMD_RREG, CFG0_ADDR, {CFG0_DEFAULT, 16'h0}, 2);
        rd(CMD_RREG, CFG1_ADDR, {CFG1_DEFAULT, 16'h0}, 2);
        cmd(CMD_DPD);
        chk1(deep_power_down, 1'h1);
        close_out;
    end
endmodule
